// file: rtl/irf_ahb_slave.sv
// AHB-Lite slave that turns bus transfers into register accesses.
`timescale 1ns/100ps
`default_nettype none
module irf_ahb_slave (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Register side
  irf_regbus_if.bus_end regs
);

  irf_pkg::irf_bus_state_t state_q, state_d;
  logic [31:0] addr_q;
  logic word_q;
  logic [31:0] hrdata_q;

  // ----------------------------------------------------------------------
  // Address phase acceptance and data phase sequencing.
  // ----------------------------------------------------------------------
  wire accept = hsel_i && htrans_i[irf_pkg::HTRANS_ACTIVE_BIT] && hready_i;
  wire fetching = state_q == irf_pkg::IRF_BUS_RD_FETCH;

  always_comb begin
    case (state_q)
      irf_pkg::IRF_BUS_RD_FETCH: state_d = irf_pkg::IRF_BUS_RD_DONE;
      default: begin
        if (accept) begin
          state_d = hwrite_i ? irf_pkg::IRF_BUS_WRITE : irf_pkg::IRF_BUS_RD_FETCH;
        end else begin
          state_d = irf_pkg::IRF_BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= irf_pkg::IRF_BUS_IDLE;
      addr_q <= irf_pkg::ADDR_RESET;
      word_q <= 1'b0;
      hrdata_q <= irf_pkg::RST_HRDATA;
    end else begin
      state_q <= state_d;
      if (accept) begin
        addr_q <= haddr_i;
        word_q <= hsize_i == irf_pkg::HSIZE_WORD;
      end
      if (fetching) begin
        hrdata_q <= regs.rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign regs.wr_en = (state_q == irf_pkg::IRF_BUS_WRITE) && word_q;
  assign regs.addr = addr_q;
  assign regs.wdata = hwdata_i;
  assign hreadyout_o = !fetching;
  assign hresp_o = irf_pkg::HRESP_OKAY;
  assign hrdata_o = hrdata_q;

endmodule : irf_ahb_slave
`default_nettype wire

// file: rtl/irf_pkg.sv
// Constants, types and helpers shared by the interrupt request front end.
//
// Behaviour
// - Each of 32 request inputs is ORed with its software-force bit first.
// - Writing ones to software_force_set forces those requests; zeros keep; reads return force bits.
// - Writing ones to software_force_clear releases those forces; zeros leave them unchanged.
// - raw_request_status reads the combined requests, ignoring enable and category.
// - Reading request_enable_set returns ones where a request may reach an output.
// - Writing ones to request_enable_set enables those requests; zeros keep their state.
// - Writing ones to request_enable_clear disables those requests; zeros keep their state.
// - category_select is read-write and places each of 32 requests fast or normal.
// - normal_category_status shows requests asserted, enabled and normal; zero elsewhere.
// - normal_category_status makes no vectored versus non-vectored distinction.
// - Read-only fast_category_status shows requests asserted, enabled and fast.
package irf_pkg;

  // ----------------------------------------------------------------------
  // Widths.
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_REQ = 32;
  localparam int unsigned EVT_W = 2;

  // ----------------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_NORMAL_STATUS = 32'hFFFFF000;
  localparam logic [31:0] ADDR_FAST_STATUS = 32'hFFFFF004;
  localparam logic [31:0] ADDR_RAW_STATUS = 32'hFFFFF008;
  localparam logic [31:0] ADDR_CATEGORY = 32'hFFFFF00C;
  localparam logic [31:0] ADDR_ENABLE_SET = 32'hFFFFF010;
  localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'hFFFFF014;
  localparam logic [31:0] ADDR_FORCE_SET = 32'hFFFFF018;
  localparam logic [31:0] ADDR_FORCE_CLEAR = 32'hFFFFF01C;
  localparam logic [31:0] ADDR_EVT_STATUS = 32'hFFFFF040;
  localparam logic [31:0] ADDR_EVT_MASK = 32'hFFFFF044;

  // ----------------------------------------------------------------------
  // Reset values and field positions.
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_CATEGORY = 32'h00000000;
  localparam logic [31:0] RST_ENABLE = 32'h00000000;
  localparam logic [31:0] RST_FORCE = 32'h00000000;
  localparam logic [31:0] RST_HRDATA = 32'h00000000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam int unsigned EVT_FAST_BIT = 0;
  localparam int unsigned EVT_NORMAL_BIT = 1;
  localparam logic [29:0] EVT_PAD = 30'h00000000;

  // ----------------------------------------------------------------------
  // Bus encodings.
  // ----------------------------------------------------------------------
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    IRF_BUS_IDLE,
    IRF_BUS_WRITE,
    IRF_BUS_RD_FETCH,
    IRF_BUS_RD_DONE
  } irf_bus_state_t;

  // Word address match, ignoring the byte lane bits.
  function automatic logic irf_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    return addr[31:2] == reg_addr[31:2];
  endfunction : irf_hit

  // Write-one-to-set and write-one-to-clear updates.
  function automatic logic [31:0] irf_w1s(input logic [31:0] q, input logic [31:0] w);
    return q | w;
  endfunction : irf_w1s

  function automatic logic [31:0] irf_w1c(input logic [31:0] q, input logic [31:0] w);
    return q & ~w;
  endfunction : irf_w1c

endpackage : irf_pkg

// file: rtl/irf_regbus_if.sv
// Register access carrier between the bus slave and the register file.
`timescale 1ns/100ps
`default_nettype none
interface irf_regbus_if;
  logic wr_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport bus_end (
    output wr_en,
    output addr,
    output wdata,
    input rdata
  );

  modport reg_end (
    input wr_en,
    input addr,
    input wdata,
    output rdata
  );
endinterface : irf_regbus_if
`default_nettype wire

// file: rtl/irf_set_clear_reg.sv
// Register with separate write-one-to-set and write-one-to-clear ports.
`timescale 1ns/100ps
`default_nettype none
module irf_set_clear_reg (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Update strobes and data
  input wire logic set_en_i,
  input wire logic clr_en_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rst_val_i,
  // Stored value
  output logic [31:0] q_o
);

  logic [31:0] q_q;
  logic [31:0] q_d;

  // Only one of the strobes can be high, since they come from distinct addresses.
  assign q_d = set_en_i ? irf_pkg::irf_w1s(q_q, wdata_i) :
               clr_en_i ? irf_pkg::irf_w1c(q_q, wdata_i) : q_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q_q <= rst_val_i;
    end else begin
      q_q <= q_d;
    end
  end

  assign q_o = q_q;

endmodule : irf_set_clear_reg
`default_nettype wire

// file: rtl/irf_top.sv
// Interrupt request front end: request merging, enabling and categorising.
`timescale 1ns/100ps
`default_nettype none
module irf_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Peripheral request lines
  input wire logic [31:0] periph_req_i,
  // Processor interrupt lines
  output logic fast_irq_o,
  output logic normal_irq_o,
  // Event interrupt
  output logic evt_irq_o
);

  // ----------------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------------
  irf_regbus_if regs ();

  irf_ahb_slave u_bus (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .regs(regs)
  );

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  wire hit_normal = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_NORMAL_STATUS);
  wire hit_fast = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_FAST_STATUS);
  wire hit_raw = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_RAW_STATUS);
  wire hit_category = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_CATEGORY);
  wire hit_en_set = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_ENABLE_SET);
  wire hit_en_clr = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_ENABLE_CLEAR);
  wire hit_force_set = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_FORCE_SET);
  wire hit_force_clr = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_FORCE_CLEAR);
  wire hit_evt_status = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_EVT_STATUS);
  wire hit_evt_mask = irf_pkg::irf_hit(regs.addr, irf_pkg::ADDR_EVT_MASK);

  // ----------------------------------------------------------------------
  // Write strobes.
  // ----------------------------------------------------------------------
  wire wr_category = regs.wr_en && hit_category;
  wire wr_en_set = regs.wr_en && hit_en_set;
  wire wr_en_clr = regs.wr_en && hit_en_clr;
  wire wr_force_set = regs.wr_en && hit_force_set;
  wire wr_force_clr = regs.wr_en && hit_force_clr;
  wire wr_evt_status = regs.wr_en && hit_evt_status;
  wire wr_evt_mask = regs.wr_en && hit_evt_mask;

  // ----------------------------------------------------------------------
  // Software-force bits.
  // ----------------------------------------------------------------------
  logic [31:0] force_q;

  irf_set_clear_reg u_force (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_en_i(wr_force_set),
    .clr_en_i(wr_force_clr),
    .wdata_i(regs.wdata),
    .rst_val_i(irf_pkg::RST_FORCE),
    .q_o(force_q)
  );

  // ----------------------------------------------------------------------
  // Enable bits.
  // ----------------------------------------------------------------------
  logic [31:0] enable_q;

  irf_set_clear_reg u_enable (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_en_i(wr_en_set),
    .clr_en_i(wr_en_clr),
    .wdata_i(regs.wdata),
    .rst_val_i(irf_pkg::RST_ENABLE),
    .q_o(enable_q)
  );

  // ----------------------------------------------------------------------
  // Category select.
  // ----------------------------------------------------------------------
  logic [31:0] category_q;
  logic [31:0] category_d;

  assign category_d = wr_category ? regs.wdata : category_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      category_q <= irf_pkg::RST_CATEGORY;
    end else begin
      category_q <= category_d;
    end
  end

  // ----------------------------------------------------------------------
  // Request merging and categorising.
  // ----------------------------------------------------------------------
  wire [31:0] raw_req = periph_req_i | force_q;
  wire [31:0] enabled_req = raw_req & enable_q;
  wire [31:0] fast_status = enabled_req & category_q;
  wire [31:0] normal_status = enabled_req & ~category_q;
  wire fast_any = |fast_status;
  wire normal_any = |normal_status;

  assign fast_irq_o = fast_any;
  assign normal_irq_o = normal_any;

  // ----------------------------------------------------------------------
  // Event status and mask.
  // ----------------------------------------------------------------------
  logic fast_any_q;
  logic normal_any_q;
  logic [irf_pkg::EVT_W-1:0] evt_status_q;
  logic [irf_pkg::EVT_W-1:0] evt_status_d;
  logic [irf_pkg::EVT_W-1:0] evt_mask_q;
  logic [irf_pkg::EVT_W-1:0] evt_mask_d;
  logic [irf_pkg::EVT_W-1:0] evt_new;
  logic [irf_pkg::EVT_W-1:0] evt_clr;

  always_comb begin
    evt_new = irf_pkg::RST_EVT;
    evt_new[irf_pkg::EVT_FAST_BIT] = fast_any && !fast_any_q;
    evt_new[irf_pkg::EVT_NORMAL_BIT] = normal_any && !normal_any_q;
  end

  assign evt_clr = wr_evt_status ? regs.wdata[irf_pkg::EVT_W-1:0] : irf_pkg::RST_EVT;
  assign evt_status_d = (evt_status_q & ~evt_clr) | evt_new;
  assign evt_mask_d = wr_evt_mask ? regs.wdata[irf_pkg::EVT_W-1:0] : evt_mask_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fast_any_q <= 1'b0;
      normal_any_q <= 1'b0;
      evt_status_q <= irf_pkg::RST_EVT;
      evt_mask_q <= irf_pkg::RST_EVT;
    end else begin
      fast_any_q <= fast_any;
      normal_any_q <= normal_any;
      evt_status_q <= evt_status_d;
      evt_mask_q <= evt_mask_d;
    end
  end

  assign evt_irq_o = |(evt_status_q & evt_mask_q);

  // ----------------------------------------------------------------------
  // Read data selection.
  // ----------------------------------------------------------------------
  wire [31:0] rd_normal = hit_normal ? normal_status : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_fast = hit_fast ? fast_status : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_raw = hit_raw ? raw_req : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_category = hit_category ? category_q : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_enable = hit_en_set ? enable_q : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_force = hit_force_set ? force_q : irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_evt_status = hit_evt_status ? {irf_pkg::EVT_PAD, evt_status_q} :
                              irf_pkg::RDATA_UNMAPPED;
  wire [31:0] rd_evt_mask = hit_evt_mask ? {irf_pkg::EVT_PAD, evt_mask_q} :
                            irf_pkg::RDATA_UNMAPPED;

  assign regs.rdata = rd_normal | rd_fast | rd_raw | rd_category | rd_enable |
                      rd_force | rd_evt_status | rd_evt_mask;

endmodule : irf_top
`default_nettype wire

// file: tb/irf_periph_model.sv
// Peripheral request lines that follow a pattern after a chosen lag.
`timescale 1ns/100ps
`default_nettype none
module irf_periph_model (
  // Clock
  input wire logic core_clk_i,
  // Pattern and lag in cycles
  input wire logic [31:0] pattern_i,
  input wire logic [1:0] lag_i,
  // Request lines
  output var logic [31:0] periph_req_o = 32'h0
);
  logic [31:0] pend_q = 32'h0;
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge core_clk_i) begin
    if (pattern_i != pend_q) begin
      pend_q <= pattern_i;
      cnt_q <= 2'h0;
    end else if (cnt_q != lag_i) begin
      cnt_q <= cnt_q + 2'h1;
    end else begin
      periph_req_o <= pend_q;
    end
  end
endmodule : irf_periph_model
`default_nettype wire

// file: tb/irf_top_sva.sv
// Concurrent checks on the ports of the interrupt request front end.
`timescale 1ns/100ps
`default_nettype none
module irf_top_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  // Requests and interrupts
  input wire logic [31:0] periph_req_i,
  input wire logic fast_irq_o,
  input wire logic normal_irq_o,
  input wire logic evt_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // --------------------------------------------------------------------
  // Shadow of the control registers, rebuilt from bus writes.
  // --------------------------------------------------------------------
  logic wr_q;
  logic rd_q;
  logic [31:0] a_q, en_q, cat_q, frc_q;
  logic [1:0] msk_q;
  wire tk = hsel_i & htrans_i[1] & hready_i;
  wire [31:0] raw = periph_req_i | frc_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 32'h0;
      en_q <= 32'h0;
      cat_q <= 32'h0;
      frc_q <= 32'h0;
      msk_q <= 2'h0;
    end else begin
      if (hreadyout_o) begin
        wr_q <= tk & hwrite_i & (hsize_i == 3'h2);
        rd_q <= tk & !hwrite_i;
        a_q <= haddr_i;
      end
      if (wr_q & hreadyout_o) begin
        case (a_q)
          irf_pkg::ADDR_ENABLE_SET: en_q <= en_q | hwdata_i;
          irf_pkg::ADDR_ENABLE_CLEAR: en_q <= en_q & ~hwdata_i;
          irf_pkg::ADDR_CATEGORY: cat_q <= hwdata_i;
          irf_pkg::ADDR_FORCE_SET: frc_q <= frc_q | hwdata_i;
          irf_pkg::ADDR_FORCE_CLEAR: frc_q <= frc_q & ~hwdata_i;
          irf_pkg::ADDR_EVT_MASK: msk_q <= hwdata_i[1:0];
          default: ;
        endcase
      end
    end
  end
  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response is not okay");
  write_nowait_a: assert property (tk && hwrite_i |=> hreadyout_o)
    else $error("write data phase was stretched");
  read_wait_a: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not take exactly one wait state");
  wait_one_a: assert property ($fell(hreadyout_o) |=> hreadyout_o)
    else $error("ready stayed low for more than one cycle");
  fast_out_a: assert property (fast_irq_o == |(raw & en_q & cat_q))
    else $error("fast output differs from enabled fast requests");
  normal_out_a: assert property (normal_irq_o == |(raw & en_q & ~cat_q))
    else $error("normal output differs from enabled normal requests");
  enable_read_a: assert property (rd_q && hreadyout_o && a_q == irf_pkg::ADDR_ENABLE_SET
    |-> hrdata_o == en_q)
    else $error("enable readback differs from enable state");
  category_read_a: assert property (rd_q && hreadyout_o && a_q == irf_pkg::ADDR_CATEGORY
    |-> hrdata_o == cat_q)
    else $error("category readback differs from written value");
  evt_masked_a: assert property (msk_q == 2'h0 |-> !evt_irq_o)
    else $error("event interrupt raised while fully masked");
endmodule : irf_top_sva
bind irf_top irf_top_sva i_irf_top_sva (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
  .periph_req_i(periph_req_i), .fast_irq_o(fast_irq_o), .normal_irq_o(normal_irq_o),
  .evt_irq_o(evt_irq_o)
);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the interrupt request front end.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] pat = 32'h0;
  logic [1:0] lag = 2'h0;
  wire hreadyout_o;
  wire hresp_o;
  wire [31:0] hrdata_o;
  wire [31:0] periph_req;
  wire fast_irq_o;
  wire normal_irq_o;
  wire evt_irq_o;
  logic [31:0] en = '0, cat = '0, frc = '0, req = '0, rnd = 32'h0001826A;
  logic [1:0] ev = '0, msk = '0;
  logic [34:0] notes[$];
  logic busy = 1'b0;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] ad [9] = '{irf_pkg::ADDR_NORMAL_STATUS, irf_pkg::ADDR_FAST_STATUS,
    irf_pkg::ADDR_RAW_STATUS, irf_pkg::ADDR_CATEGORY, irf_pkg::ADDR_ENABLE_SET,
    irf_pkg::ADDR_ENABLE_CLEAR, irf_pkg::ADDR_FORCE_SET, irf_pkg::ADDR_FORCE_CLEAR, 32'hFFFFF080};
  logic [31:0] wa [8] = '{irf_pkg::ADDR_ENABLE_SET, irf_pkg::ADDR_ENABLE_CLEAR,
    irf_pkg::ADDR_CATEGORY, irf_pkg::ADDR_FORCE_SET, irf_pkg::ADDR_FORCE_CLEAR,
    irf_pkg::ADDR_RAW_STATUS, 32'hFFFFF080, irf_pkg::ADDR_FORCE_SET};
  irf_top i_irf_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .periph_req_i(periph_req), .fast_irq_o(fast_irq_o),
    .normal_irq_o(normal_irq_o), .evt_irq_o(evt_irq_o));
  irf_periph_model i_irf_periph_model (.core_clk_i(core_clk_i), .pattern_i(pat),
    .lag_i(lag), .periph_req_o(periph_req));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    logic [31:0] y;
    y = x;
    repeat (32) y = {y[30:0], y[31] ^ y[21] ^ y[1] ^ y[0]};
    return y;
  endfunction : lfsr
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    case (a)
      irf_pkg::ADDR_NORMAL_STATUS: return (req | frc) & en & ~cat;
      irf_pkg::ADDR_FAST_STATUS: return (req | frc) & en & cat;
      irf_pkg::ADDR_RAW_STATUS: return req | frc;
      irf_pkg::ADDR_CATEGORY: return cat;
      irf_pkg::ADDR_ENABLE_SET: return en;
      irf_pkg::ADDR_FORCE_SET: return frc;
      irf_pkg::ADDR_EVT_STATUS: return {30'h0, ev};
      irf_pkg::ADDR_EVT_MASK: return {30'h0, msk};
      default: return 32'h0;
    endcase
  endfunction : exp_rd
  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: read data %h, expected %h", $time, g, e);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: interrupt line %b, expected %b", $time, g, e);
    end
  endtask : cmp_bit
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (hreadyout_o !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: bus ready never returned", $time);
    end
  endtask : wait_rdy
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] s);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    hsize_i <= s;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    if (w) hwdata_i <= d;
    wait_rdy();
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] s = 3'h2);
    bus(a, 1'b1, d, s);
    if (s == 3'h2) begin
      case (a)
        irf_pkg::ADDR_ENABLE_SET: en = en | d;
        irf_pkg::ADDR_ENABLE_CLEAR: en = en & ~d;
        irf_pkg::ADDR_CATEGORY: cat = d;
        irf_pkg::ADDR_FORCE_SET: frc = frc | d;
        irf_pkg::ADDR_FORCE_CLEAR: frc = frc & ~d;
        irf_pkg::ADDR_EVT_STATUS: ev = ev & ~d[1:0];
        irf_pkg::ADDR_EVT_MASK: msk = d[1:0];
        default: ;
      endcase
    end
  endtask : wr
  task automatic rd(input logic [31:0] a);
    notes.push_back({|(ev & msk), |exp_rd(irf_pkg::ADDR_FAST_STATUS),
      |exp_rd(irf_pkg::ADDR_NORMAL_STATUS), exp_rd(a)});
    bus(a, 1'b0, 32'h0, 3'h2);
  endtask : rd
  // Each finished read is compared with the oldest note.
  always @(negedge core_clk_i) begin
    if (busy && hreadyout_o) begin
      cmp_word(notes[0][31:0], hrdata_o);
      cmp_bit(notes[0][32], normal_irq_o);
      cmp_bit(notes[0][33], fast_irq_o);
      cmp_bit(notes[0][34], evt_irq_o);
      void'(notes.pop_front());
      busy = 1'b0;
    end
    if (hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o) busy = 1'b1;
  end
  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    errors++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int k = 0; k < 9; k++) rd(ad[k]);
    for (int r = 0; r < 12; r++) begin
      rnd = lfsr(rnd);
      pat <= rnd;
      lag <= rnd[9:8];
      req = rnd;
      repeat (6) @(posedge core_clk_i);
      for (int k = 0; k < 8; k++) begin
        rnd = lfsr(rnd);
        wr(wa[k], rnd, k == 7 ? 3'h0 : 3'h2);
      end
      for (int k = 0; k < 9; k++) rd(ad[k]);
    end
    wr(irf_pkg::ADDR_ENABLE_CLEAR, 32'hFFFFFFFF);
    wr(irf_pkg::ADDR_FORCE_CLEAR, 32'hFFFFFFFF);
    wr(irf_pkg::ADDR_EVT_STATUS, 32'h00000003);
    wr(irf_pkg::ADDR_EVT_MASK, 32'h00000003);
    rd(irf_pkg::ADDR_EVT_STATUS);
    wr(irf_pkg::ADDR_CATEGORY, 32'h00000001);
    wr(irf_pkg::ADDR_ENABLE_SET, 32'h00000003);
    wr(irf_pkg::ADDR_FORCE_SET, 32'h00000003);
    ev = 2'h3;
    rd(irf_pkg::ADDR_EVT_STATUS);
    wr(irf_pkg::ADDR_EVT_MASK, 32'h00000000);
    rd(irf_pkg::ADDR_EVT_MASK);
    wr(irf_pkg::ADDR_EVT_STATUS, 32'h00000001);
    wr(irf_pkg::ADDR_EVT_MASK, 32'h00000002);
    rd(irf_pkg::ADDR_EVT_STATUS);
    @(negedge core_clk_i);
    final_report();
  end
endmodule : testbench
`default_nettype wire
